// ===== design/smc_pkg.sv
// Package for the subsystem mode controller: modes, timing counts, carriers.
// Assumes a single system clock at 20 MHz.
package smc_pkg;

  localparam int unsigned SMC_CLK_HZ = 20_000_000;
  // Power loss longer than this forces failure mode
  localparam int unsigned SMC_PWR_LOSS_MS = 20;
  localparam int unsigned SMC_PWR_LOSS_CYC = SMC_PWR_LOSS_MS * (SMC_CLK_HZ / 1000);
  localparam int unsigned SMC_CNT_W = 20;
  localparam int unsigned SMC_SYNC_W = 3;

  typedef enum logic [0:0] {
    SMC_FAILURE,
    SMC_CONTROL
  } smc_mode_t;

  // Raw external condition inputs
  typedef struct packed {
    logic fatal_fault;
    logic minor_alarm;
    logic io_alarm;
    logic power_good;
    logic reset_button;
  } smc_in_t;

  // Mode and indication outputs
  typedef struct packed {
    logic control_mode;
    logic failure_mode;
    logic io_enable;
    logic op_enable;
    logic warn_minor;
    logic warn_io;
  } smc_out_t;

  // Three-flop synchroniser stage per input bit
  typedef struct packed {
    logic [SMC_SYNC_W-1:0] fatal_fault;
    logic [SMC_SYNC_W-1:0] minor_alarm;
    logic [SMC_SYNC_W-1:0] io_alarm;
    logic [SMC_SYNC_W-1:0] power_good;
    logic [SMC_SYNC_W-1:0] reset_button;
  } smc_sync_t;

  localparam logic [SMC_SYNC_W-1:0] SMC_SYNC_RST = 3'h0;
  localparam logic [SMC_SYNC_W-1:0] SMC_PG_SYNC_RST = 3'h0;

endpackage

// ===== design/smc_mode_ctrl.sv
// Subsystem mode controller: failure/control mode tracking and warnings.
// Assumes all condition inputs are asynchronous pins; one clock sys_clk.
//
// Function
// RQ1: After power-up reset the subsystem comes up in failure mode.
// RQ2: A fatal fault from self-diagnosis forces failure mode from any mode.
// RQ3: A power loss lasting longer than 20 ms forces failure mode; shorter drops do not.
// RQ4: Only a press of the operator reset button moves failure mode to control mode.
// RQ5: In failure mode all I/O and operation processing is halted.
// RQ6: In control mode input, operation, output and self-diagnosis processing run.
// RQ7: A minor abnormality raises a warning and leaves the mode unchanged.
// RQ8: An I/O abnormality raises an I/O alarm warning and leaves the mode unchanged.
// RQ9: Power-loss time is counted in clock cycles from power-good going low.
`timescale 1ns/1ns
module smc_mode_ctrl
  import smc_pkg::*;
#(
  parameter int unsigned PWR_LOSS_CYC = SMC_PWR_LOSS_CYC
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Condition inputs from diagnosis, power monitor and pushbutton
  input wire smc_in_t cond_in,
  // Mode and warning outputs
  output smc_out_t status
);

  typedef struct packed {
    smc_sync_t sync;
    smc_in_t filt;
    logic btn_prev;
    logic [SMC_CNT_W-1:0] loss_cnt;
    smc_mode_t mode;
    smc_out_t out;
  } smc_state_t;

  localparam smc_state_t SMC_STATE_RST = '{
    sync: '{SMC_SYNC_RST, SMC_SYNC_RST, SMC_SYNC_RST, SMC_PG_SYNC_RST, SMC_SYNC_RST},
    filt: '0,
    btn_prev: 1'b0,
    loss_cnt: '0,
    mode: SMC_FAILURE,
    out: '{control_mode: 1'b0, failure_mode: 1'b1, io_enable: 1'b0, op_enable: 1'b0,
           warn_minor: 1'b0, warn_io: 1'b0}
  };

  localparam logic [SMC_CNT_W-1:0] LOSS_LIMIT = SMC_CNT_W'(PWR_LOSS_CYC);

  smc_state_t st;
  smc_state_t next_st;

  // Accept a new level once the second and third stage agree
  function automatic logic smc_filter(input logic [SMC_SYNC_W-1:0] s, input logic old);
    smc_filter = (s[1] == s[2]) ? s[2] : old;
  endfunction

  always_comb begin
    logic btn_press;
    logic loss_long;
    btn_press = 1'b0;
    loss_long = 1'b0;
    next_st = st;
    next_st.sync.fatal_fault = {st.sync.fatal_fault[1:0], cond_in.fatal_fault};
    next_st.sync.minor_alarm = {st.sync.minor_alarm[1:0], cond_in.minor_alarm};
    next_st.sync.io_alarm = {st.sync.io_alarm[1:0], cond_in.io_alarm};
    next_st.sync.power_good = {st.sync.power_good[1:0], cond_in.power_good};
    next_st.sync.reset_button = {st.sync.reset_button[1:0], cond_in.reset_button};
    next_st.filt.fatal_fault = smc_filter(st.sync.fatal_fault, st.filt.fatal_fault);
    next_st.filt.minor_alarm = smc_filter(st.sync.minor_alarm, st.filt.minor_alarm);
    next_st.filt.io_alarm = smc_filter(st.sync.io_alarm, st.filt.io_alarm);
    next_st.filt.power_good = smc_filter(st.sync.power_good, st.filt.power_good);
    next_st.filt.reset_button = smc_filter(st.sync.reset_button, st.filt.reset_button);
    next_st.btn_prev = st.filt.reset_button;
    btn_press = st.filt.reset_button && !st.btn_prev;
    // Count loss duration, saturating just past the limit
    if (st.filt.power_good) begin
      next_st.loss_cnt = '0; // RQ9
    end else if (st.loss_cnt <= LOSS_LIMIT) begin
      next_st.loss_cnt = st.loss_cnt + 1'b1; // RQ9
    end
    loss_long = (st.loss_cnt > LOSS_LIMIT); // RQ3
    case (st.mode)
      SMC_FAILURE: begin
        // Release blocked while any failure cause is still present
        if (btn_press && !st.filt.fatal_fault && !loss_long) begin
          next_st.mode = SMC_CONTROL; // RQ4
        end
      end
      SMC_CONTROL: begin
        if (st.filt.fatal_fault) begin
          next_st.mode = SMC_FAILURE; // RQ2
        end else if (loss_long) begin
          next_st.mode = SMC_FAILURE; // RQ3
        end
      end
      default: begin
        next_st.mode = SMC_FAILURE;
      end
    endcase
    next_st.out.control_mode = (next_st.mode == SMC_CONTROL); // RQ6
    next_st.out.failure_mode = (next_st.mode == SMC_FAILURE);
    next_st.out.io_enable = (next_st.mode == SMC_CONTROL); // RQ5
    next_st.out.op_enable = (next_st.mode == SMC_CONTROL); // RQ5
    next_st.out.warn_minor = st.filt.minor_alarm; // RQ7
    next_st.out.warn_io = st.filt.io_alarm; // RQ8
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= SMC_STATE_RST; // RQ1
    end else begin
      st <= next_st;
    end
  end

  assign status = st.out;

endmodule // smc_mode_ctrl

// ===== test/smc_mode_ctrl_assertions.sv
// Port checker for the mode controller.
// Assumes one clock; bound to smc_mode_ctrl.
`timescale 1ns/1ns
module smc_checker
  import smc_pkg::*;
#(parameter int unsigned PWR_LOSS_CYC = SMC_PWR_LOSS_CYC) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // Watched ports
  input wire smc_in_t cond_in,
  input wire smc_out_t status
);
  int unsigned lo;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) lo <= 32'h0;
    else lo <= cond_in.power_good ? 32'h0 : lo + 32'h1;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  a_start_failed: assert property ($rose(rst_n) |-> status.failure_mode)
    else $error("start");
  a_fatal_fails: assert property (cond_in.fatal_fault[*3] |-> ##[0:4] status.failure_mode)
    else $error("fatal");
  a_long_loss: assert property (lo == PWR_LOSS_CYC + 8 |-> status.failure_mode)
    else $error("loss");
  a_button_only: assert property
    (!cond_in.reset_button[*6] ##1 status.failure_mode |=> status.failure_mode) else $error("leave");
  a_fail_halts: assert property
    (status.failure_mode |-> !status.io_enable && !status.op_enable) else $error("halt");
  a_ctrl_runs: assert property
    (status.control_mode |-> status.io_enable && status.op_enable && !status.failure_mode)
    else $error("run");
  a_minor_warn: assert property (cond_in.minor_alarm[*6] |-> status.warn_minor)
    else $error("minor");
  a_io_warn: assert property (cond_in.io_alarm[*6] |-> status.warn_io)
    else $error("io");
  cover property ($rose(status.control_mode));
  cover property (lo == 32'h28 && status.control_mode);
  cover property (status.warn_io && status.control_mode);
endmodule // smc_checker
bind smc_mode_ctrl smc_checker #(.PWR_LOSS_CYC(PWR_LOSS_CYC)) smc_checker_i
  (.sys_clk(sys_clk), .rst_n(rst_n), .cond_in(cond_in), .status(status));

// ===== test/smc_partner.sv
// Diagnosis, power monitor and pushbutton model.
// Assumes the bench calls its tasks; pins move on falling edges.
`timescale 1ns/1ns
module smc_partner
  import smc_pkg::*;
(
  // Clock
  input wire logic sys_clk,
  // Condition pins
  output smc_in_t cond
);
  initial cond = 5'h02;
  task automatic press();
    @(negedge sys_clk) cond.reset_button = 1'b1;
    repeat (4) @(negedge sys_clk);
    cond.reset_button = 1'b0;
  endtask
  task automatic pins(input logic ff, mi, ia, pg);
    @(negedge sys_clk) cond = '{ff, mi, ia, pg, 1'b0};
  endtask
endmodule // smc_partner

// ===== test/smc_mode_ctrl_test.sv
// Bench for the mode controller.
// Assumes smc_partner drives the pins; loss limit cut to 50 cycles.
`timescale 1ns/1ns
module smc_mode_ctrl_test
  import smc_pkg::*;
;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  smc_in_t cond_in;
  smc_out_t status;
  int err_total = 0;
  int n_checks = 0;
  int cyc = 0;
  smc_partner smc_partner_i (.sys_clk(sys_clk), .cond(cond_in));
  smc_mode_ctrl #(.PWR_LOSS_CYC(50)) smc_mode_ctrl_i
    (.sys_clk(sys_clk), .rst_n(rst_n), .cond_in(cond_in), .status(status));
  initial forever #25 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      err_total++;
      $display("ERROR %0t timeout", $time);
      give_verdict();
    end
  end
  task automatic mode(input logic c, input string w);
    repeat (8) @(negedge sys_clk);
    n_checks++;
    if (status[5:2] !== {c, !c, c, c}) begin
      err_total++;
      $display("ERROR %0t mode %s", $time, w);
    end
  endtask
  task automatic t_warn(input logic a);
    smc_partner_i.pins(1'b0, a, a, 1'b1);
    mode(1'b1, "alarm");
    n_checks++;
    if (status[1:0] !== {a, a}) begin
      err_total++;
      $display("ERROR %0t warn", $time);
    end
  endtask
  task automatic give_verdict();
    if (err_total == 0 && n_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  initial begin
    repeat (4) @(negedge sys_clk);
    rst_n = 1'b1;
    mode(1'b0, "start");
    smc_partner_i.press();
    mode(1'b1, "press");
    t_warn(1'b1);
    t_warn(1'b0);
    smc_partner_i.pins(1'b1, 1'b0, 1'b0, 1'b1);
    mode(1'b0, "fatal");
    smc_partner_i.press();
    mode(1'b0, "held");
    smc_partner_i.pins(1'b0, 1'b0, 1'b0, 1'b1);
    mode(1'b0, "clear");
    smc_partner_i.press();
    mode(1'b1, "again");
    smc_partner_i.pins(1'b0, 1'b0, 1'b0, 1'b0);
    repeat (32) @(negedge sys_clk);
    smc_partner_i.pins(1'b0, 1'b0, 1'b0, 1'b1);
    mode(1'b1, "short");
    smc_partner_i.pins(1'b0, 1'b0, 1'b0, 1'b0);
    repeat (50) @(negedge sys_clk);
    mode(1'b0, "long");
    smc_partner_i.pins(1'b0, 1'b0, 1'b0, 1'b1);
    mode(1'b0, "restore");
    smc_partner_i.press();
    mode(1'b1, "back");
    give_verdict();
  end
endmodule // smc_mode_ctrl_test
